// >>> pkg/iolm_pkg.sv
package iolm_pkg;

   // ******************************************************************
   // Bus geometry
   // ******************************************************************
   localparam int ADR_W = 9;
   localparam int DAT_W = 32;
   localparam int LINES = 32;

   // ******************************************************************
   // Register byte offsets
   // ******************************************************************
   localparam logic [8:0] OFS_LINE_EN     = 9'h000;
   localparam logic [8:0] OFS_LINE_DIS    = 9'h004;
   localparam logic [8:0] OFS_OUT_EN      = 9'h010;
   localparam logic [8:0] OFS_OUT_DIS     = 9'h014;
   localparam logic [8:0] OFS_FILT_EN     = 9'h020;
   localparam logic [8:0] OFS_FILT_DIS    = 9'h024;
   localparam logic [8:0] OFS_MDRV_EN     = 9'h050;
   localparam logic [8:0] OFS_MDRV_DIS    = 9'h054;
   localparam logic [8:0] OFS_PULLUP_DIS  = 9'h060;
   localparam logic [8:0] OFS_PULLUP_EN   = 9'h064;
   localparam logic [8:0] OFS_PSEL1       = 9'h070;
   localparam logic [8:0] OFS_PSEL2       = 9'h074;
   localparam logic [8:0] OFS_PDOWN_DIS   = 9'h090;
   localparam logic [8:0] OFS_PDOWN_EN    = 9'h094;
   localparam logic [8:0] OFS_PDOWN_STAT  = 9'h098;
   localparam logic [8:0] OFS_OWR_EN      = 9'h0A0;
   localparam logic [8:0] OFS_OWR_DIS     = 9'h0A4;
   localparam logic [8:0] OFS_EXTRA_EN    = 9'h0B0;
   localparam logic [8:0] OFS_EXTRA_DIS   = 9'h0B4;
   localparam logic [8:0] OFS_EXTRA_MASK  = 9'h0B8;
   localparam logic [8:0] OFS_EDGE_SET    = 9'h0C0;
   localparam logic [8:0] OFS_LEVEL_SET   = 9'h0C4;
   localparam logic [8:0] OFS_EL_STATUS   = 9'h0C8;
   localparam logic [8:0] OFS_FALL_SET    = 9'h0D0;
   localparam logic [8:0] OFS_RISE_SET    = 9'h0D4;
   localparam logic [8:0] OFS_POL_STATUS  = 9'h0D8;
   localparam logic [8:0] OFS_LOCK_STATUS = 9'h0E0;
   localparam logic [8:0] OFS_PROT_MODE   = 9'h0E4;
   localparam logic [8:0] OFS_PROT_STATUS = 9'h0E8;
   localparam logic [8:0] OFS_PCAP_MODE   = 9'h150;

   // ******************************************************************
   // Field layout and reset values
   // ******************************************************************
   localparam int          PROT_EN_BIT  = 0;
   localparam int          KEY_LSB      = 8;
   localparam int          KEY_MSB      = 31;
   localparam logic [23:0] PROT_KEY     = 24'h50494F;
   localparam int          VFLAG_BIT    = 0;
   localparam int          VSRC_LSB     = 8;
   localparam int          VSRC_MSB     = 23;
   localparam logic [31:0] RST_LINES    = 32'h0000_0000;
   localparam logic [15:0] RST_VSRC     = 16'h0000;
   localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

   // ******************************************************************
   // Carriers
   // ******************************************************************
   typedef struct packed {
      logic [31:0] adr;
      logic [31:0] dat;
      logic [3:0]  sel;
      logic        we;
      logic        cyc;
      logic        stb;
   } iolm_wb_req_t;

   typedef struct packed {
      logic [31:0] dat;
      logic        ack;
   } iolm_wb_rsp_t;

   typedef struct packed {
      logic [31:0] mode_en;
      logic [31:0] level;
      logic [31:0] high;
   } iolm_irq_cfg_t;

   typedef struct packed {
      logic        we;
      logic [8:0]  adr;
      logic [31:0] dat;
   } iolm_ext_wr_t;

   typedef struct packed {
      iolm_wb_rsp_t  rsp;
      iolm_irq_cfg_t cfg;
      iolm_ext_wr_t  ext;
      logic          prot_en;
      logic          viol;
      logic [15:0]   vsrc;
   } iolm_state_t;

endpackage

// >>> design/iolm_top.sv
`timescale 1ns/1ps

// How it works
// - A one in edge_mode_set selects edge detection; zeros do nothing.
// - A one in level_mode_set selects level detection; zeros do nothing.
// - edge_level_status reads zero for edge, one for level, per line.
// - A one in fall_low_set selects falling edge or low level.
// - A one in rise_high_set selects rising edge or high level.
// - polarity_status reads zero for falling/low, one for rising/high.
// - line_lock_status reads one for each locked line, zero otherwise.
// - Protection turns on only when the written key matches.
// - Protection turns off only when the written key matches.
// - With protection on, writes to guarded port registers are blocked.
// - A wrong key in a protect_mode write leaves protect_enable alone.
// - The key field of protect_mode always reads as zero.
// - violation_flag sets on a violation and holds until status is read.
// - A blocked write records the target offset in violation_source.
// - Reading protect_status clears every field in it.
// - Without extra modes a line detects both edges, selects ignored.
module iolm_top (
   input  wire logic                    CLK_I,
   input  wire logic                    SRST_I,
   input  wire logic [iolm_pkg::ADR_W-1:2] ADR_I,
   input  wire logic [31:0]             DAT_I,
   input  wire logic [3:0]              SEL_I,
   input  wire logic                    WE_I,
   input  wire logic                    CYC_I,
   input  wire logic                    STB_I,
   output logic      [31:0]             DAT_O,
   output logic                         ACK_O,
   input  wire logic [31:0]             LINE_LOCK_I,
   output logic      [31:0]             IRQ_MODE_EN_O,
   output logic      [31:0]             IRQ_LEVEL_O,
   output logic      [31:0]             IRQ_HIGH_O,
   output logic                         EXT_WE_O,
   output logic      [8:0]              EXT_ADR_O,
   output logic      [31:0]             EXT_DAT_O
);
   import iolm_pkg::*;

   // ******************************************************************
   // Decode helpers
   // ******************************************************************
   function automatic logic is_protected(input logic [8:0] ofs);
      case (ofs)
         OFS_LINE_EN, OFS_LINE_DIS, OFS_OUT_EN, OFS_OUT_DIS,
         OFS_FILT_EN, OFS_FILT_DIS, OFS_MDRV_EN, OFS_MDRV_DIS,
         OFS_PULLUP_DIS, OFS_PULLUP_EN, OFS_PSEL1, OFS_PSEL2,
         OFS_OWR_EN, OFS_OWR_DIS, OFS_PDOWN_DIS, OFS_PDOWN_EN,
         OFS_PDOWN_STAT, OFS_PCAP_MODE:
            is_protected = 1'b1;
         default:
            is_protected = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // ******************************************************************
   // State
   // ******************************************************************
   iolm_state_t  st_r;
   iolm_state_t  st_nxt;
   logic [8:0]   ofs;
   logic [31:0]  wdat;
   logic         req;
   logic         wr;
   logic         rd;
   logic         key_ok;

   assign ofs    = {ADR_I, 2'b00};
   assign wdat   = DAT_I & lane_mask(SEL_I);
   // A new access is answered once; ack is dropped in the following cycle.
   assign req    = CYC_I & STB_I & ~st_r.rsp.ack;
   assign wr     = req & WE_I;
   assign rd     = req & ~WE_I;
   // A write that leaves out byte lane 1, 2 or 3 cannot carry the whole key, so it never matches.
   assign key_ok = (wdat[KEY_MSB:KEY_LSB] == PROT_KEY);

   always_comb begin
      st_nxt          = st_r;
      st_nxt.rsp.ack  = req;
      st_nxt.rsp.dat  = ZERO_WORD;
      st_nxt.ext.we   = 1'b0;

      // ***************************************************************
      // Writes
      // ***************************************************************
      if (wr) begin
         case (ofs)
            OFS_EXTRA_EN:
               st_nxt.cfg.mode_en = st_r.cfg.mode_en | wdat;
            OFS_EXTRA_DIS:
               st_nxt.cfg.mode_en = st_r.cfg.mode_en & ~wdat;
            OFS_EDGE_SET:
               st_nxt.cfg.level = st_r.cfg.level & ~wdat;
            OFS_LEVEL_SET:
               st_nxt.cfg.level = st_r.cfg.level | wdat;
            OFS_FALL_SET:
               st_nxt.cfg.high = st_r.cfg.high & ~wdat;
            OFS_RISE_SET:
               st_nxt.cfg.high = st_r.cfg.high | wdat;
            OFS_PROT_MODE: begin
               if (key_ok) begin
                  st_nxt.prot_en = wdat[PROT_EN_BIT];
               end
            end
            default: begin
               if (is_protected(ofs) && st_r.prot_en) begin
                  // The write is dropped here and never reaches the port.
                  st_nxt.viol = 1'b1;
                  st_nxt.vsrc = {7'h00, ofs};
               end else if (is_protected(ofs)) begin
                  st_nxt.ext.we  = 1'b1;
                  st_nxt.ext.adr = ofs;
                  st_nxt.ext.dat = DAT_I;
               end
            end
         endcase
      end

      // ***************************************************************
      // Reads
      // ***************************************************************
      if (rd) begin
         case (ofs)
            OFS_EXTRA_MASK:
               st_nxt.rsp.dat = st_r.cfg.mode_en;
            OFS_EL_STATUS:
               st_nxt.rsp.dat = st_r.cfg.level;
            OFS_POL_STATUS:
               st_nxt.rsp.dat = st_r.cfg.high;
            OFS_LOCK_STATUS:
               st_nxt.rsp.dat = LINE_LOCK_I;
            OFS_PROT_MODE: begin
               st_nxt.rsp.dat = ZERO_WORD;
               st_nxt.rsp.dat[PROT_EN_BIT] = st_r.prot_en;
            end
            OFS_PROT_STATUS: begin
               st_nxt.rsp.dat[VFLAG_BIT] = st_r.viol;
               st_nxt.rsp.dat[VSRC_MSB:VSRC_LSB] = st_r.vsrc;
               st_nxt.viol = 1'b0;
               st_nxt.vsrc = RST_VSRC;
            end
            default:
               st_nxt.rsp.dat = ZERO_WORD;
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         st_r.rsp.ack     <= 1'b0;
         st_r.rsp.dat     <= ZERO_WORD;
         st_r.cfg.mode_en <= RST_LINES;
         st_r.cfg.level   <= RST_LINES;
         st_r.cfg.high    <= RST_LINES;
         st_r.ext.we      <= 1'b0;
         st_r.ext.adr     <= 9'h000;
         st_r.ext.dat     <= ZERO_WORD;
         st_r.prot_en     <= 1'b0;
         st_r.viol        <= 1'b0;
         st_r.vsrc        <= RST_VSRC;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ******************************************************************
   // Outputs
   // ******************************************************************
   // A line without extra modes shows both-edge detection downstream.
   assign DAT_O         = st_r.rsp.dat;
   assign ACK_O         = st_r.rsp.ack;
   assign IRQ_MODE_EN_O = st_r.cfg.mode_en;
   assign IRQ_LEVEL_O   = st_r.cfg.level;
   assign IRQ_HIGH_O    = st_r.cfg.high;
   assign EXT_WE_O      = st_r.ext.we;
   assign EXT_ADR_O     = st_r.ext.adr;
   assign EXT_DAT_O     = st_r.ext.dat;

endmodule

// >>> verif/iolm_props.sv
`timescale 1ns/1ps
module iolm_props (
   input wire logic        CLK_I,
   input wire logic        SRST_I,
   input wire logic [8:2]  ADR_I,
   input wire logic [31:0] DAT_I,
   input wire logic [3:0]  SEL_I,
   input wire logic        WE_I,
   input wire logic        CYC_I,
   input wire logic        STB_I,
   input wire logic [31:0] DAT_O,
   input wire logic        ACK_O,
   input wire logic [31:0] LINE_LOCK_I,
   input wire logic [31:0] IRQ_MODE_EN_O,
   input wire logic [31:0] IRQ_LEVEL_O,
   input wire logic [31:0] IRQ_HIGH_O,
   input wire logic        EXT_WE_O,
   input wire logic [8:0]  EXT_ADR_O,
   input wire logic [31:0] EXT_DAT_O
);
   wire tk = CYC_I & STB_I & ~ACK_O;
   wire wf = tk & WE_I & (SEL_I == 4'hF);
   wire rd = tk & ~WE_I;
   // Mirror of the protection enable, rebuilt from keyed bus writes.
   logic prot_on;
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         prot_on <= 1'b0;
      end else if (tk && WE_I && ADR_I == 7'h39 && SEL_I[3:1] == 3'h7
                   && DAT_I[31:8] == 24'h50494F) begin
         prot_on <= DAT_I[0] & SEL_I[0];
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   chk_edge_set:
   assert property (wf && ADR_I == 7'h30 |=> (IRQ_LEVEL_O & $past(DAT_I)) == 0)
      else $error("edge select not applied");
   chk_level_set:
   assert property (wf && ADR_I == 7'h31 |=> &(IRQ_LEVEL_O | ~$past(DAT_I)))
      else $error("level select not applied");
   chk_el_read:
   assert property (rd && ADR_I == 7'h32 |=> DAT_O == IRQ_LEVEL_O)
      else $error("edge level status wrong");
   chk_fall_set:
   assert property (wf && ADR_I == 7'h34 |=> (IRQ_HIGH_O & $past(DAT_I)) == 0)
      else $error("fall select not applied");
   chk_rise_set:
   assert property (wf && ADR_I == 7'h35 |=> &(IRQ_HIGH_O | ~$past(DAT_I)))
      else $error("rise select not applied");
   chk_pol_read:
   assert property (rd && ADR_I == 7'h36 |=> DAT_O == IRQ_HIGH_O)
      else $error("polarity status wrong");
   chk_lock_read:
   assert property (rd && ADR_I == 7'h38 |=> DAT_O == $past(LINE_LOCK_I))
      else $error("lock status wrong");
   chk_key_zero:
   assert property (rd && ADR_I == 7'h39 |=> DAT_O[31:8] == 24'h0)
      else $error("key field not zero");
   chk_wo_zero:
   assert property (rd && ADR_I inside {7'h30, 7'h31, 7'h34, 7'h35}
      |=> DAT_O == 32'h0) else $error("write-only read not zero");
   chk_ext_adr:
   assert property (EXT_WE_O |-> $past(tk & WE_I)
      && EXT_ADR_O == {$past(ADR_I), 2'b00})
      else $error("forwarded write without cause");
   chk_ext_dat:
   assert property (EXT_WE_O |-> EXT_DAT_O == $past(DAT_I))
      else $error("forwarded data wrong");
   chk_blocked_drop:
   assert property (tk && WE_I && prot_on
      && ADR_I inside {7'h00, 7'h1C, 7'h54} |=> !EXT_WE_O)
      else $error("protected write was forwarded");
endmodule
bind iolm_top iolm_props iolm_props_inst (.*);

// >>> verif/iolm_lines_model.sv
`timescale 1ns/1ps
// Pad-side lock latches; lock state settles one clock after a change.
module iolm_lines_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] lock_i,
   output logic      [31:0] lock_o
);
   always_ff @(posedge clk_i) begin
      lock_o <= lock_i;
   end
endmodule

// >>> verif/iolm_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module iolm_top_tb;
   import iolm_pkg::*;
   iolm_wb_req_t req = '0;
   logic         clk = 1'b0;
   logic         srst = 1'b1;
   logic         ack, ext_we;
   logic [8:0]   ext_adr;
   logic [31:0]  rdat, lock, dat_o, mode_en, high, level, ext_dat;
   logic [31:0]  pat = 32'h0;
   int           n_fail = 0, checks_done = 0, n_ext = 0, n_cyc = 0;
   iolm_lines_model iolm_lines_model_inst (.clk_i(clk), .lock_i(pat),
      .lock_o(lock));
   iolm_top iolm_top_inst (.CLK_I(clk), .SRST_I(srst),
      .ADR_I(req.adr[8:2]), .DAT_I(req.dat), .SEL_I(req.sel), .WE_I(req.we),
      .CYC_I(req.cyc), .STB_I(req.stb), .DAT_O(dat_o), .ACK_O(ack),
      .LINE_LOCK_I(lock), .IRQ_MODE_EN_O(mode_en), .IRQ_LEVEL_O(level),
      .IRQ_HIGH_O(high), .EXT_WE_O(ext_we), .EXT_ADR_O(ext_adr),
      .EXT_DAT_O(ext_dat));
   initial begin
      forever #12.5 clk = ~clk;
   end
   // ****
   // Bus access and the closing report
   // ****
   task automatic wb(input logic [8:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      req <= '{adr: 32'(a), dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
      do @(posedge clk); while (ack !== 1'b1);
      rdat = dat_o;
      req <= '0;
   endtask
   task automatic rd(input logic [8:0] a, input logic [31:0] e, string n);
      wb(a, 1'b0, 32'h0);
      `CHK(n, e, rdat)
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Counting runs on the clock so a hung handshake still ends the run.
   always @(posedge clk) begin
      if (ext_we === 1'b1) n_ext <= n_ext + 1;
      n_cyc <= n_cyc + 1;
      if (n_cyc == 2000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic t_modes();
      wb(9'h0C4, 1'b1, 32'h0000_00F0);
      wb(9'h0C0, 1'b1, 32'h0000_0030);
      rd(9'h0C8, 32'h0000_00C0, "el");
      `CHK("level", 32'h0000_00C0, level)
      wb(9'h0D4, 1'b1, 32'hA5A5_0000);
      wb(9'h0D0, 1'b1, 32'h0005_0000);
      rd(9'h0D8, 32'hA5A0_0000, "pol");
      `CHK("high", 32'hA5A0_0000, high)
      rd(9'h0C0, 32'h0, "wo");
      wb(9'h0B0, 1'b1, 32'h8000_0001);
      rd(9'h0B8, 32'h8000_0001, "mask");
      `CHK("mode_en", 32'h8000_0001, mode_en)
      wb(9'h0B4, 1'b1, 32'h0000_0001);
      rd(9'h0B8, 32'h8000_0000, "mask");
      `CHK("mode_en", 32'h8000_0000, mode_en)
      $display("modes done");
   endtask
   task automatic t_prot();
      int e0;
      pat <= 32'h8001_2340;
      rd(9'h0E0, 32'h8001_2340, "lock");
      wb(9'h0E4, 1'b1, 32'h5049_4E01);
      rd(9'h0E4, 32'h0, "wpm");
      wb(9'h0E4, 1'b1, {PROT_KEY, 8'h01});
      rd(9'h0E4, 32'h1, "wpm");
      e0 = n_ext;
      wb(9'h070, 1'b1, 32'h1234_5678);
      rd(9'h0E4, 32'h1, "wpm");
      rd(9'h0E8, 32'h0000_7001, "wps");
      `CHK("ext", e0, n_ext)
      `CHK("ext_dat", 32'h0, ext_dat)
      `CHK("ext_adr", 9'h000, ext_adr)
      rd(9'h0E8, 32'h0, "wps");
      wb(9'h0E4, 1'b1, {PROT_KEY, 8'h00});
      rd(9'h0E4, 32'h0, "wpm");
      wb(9'h150, 1'b1, 32'h0000_0021);
      rd(9'h0E8, 32'h0, "wps");
      `CHK("ext", e0 + 1, n_ext)
      `CHK("ext_adr", 9'h150, ext_adr)
      `CHK("ext_dat", 32'h0000_0021, ext_dat)
      rd(9'h1FC, 32'h0, "unmapped");
      $display("protect done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      t_modes();
      t_prot();
      give_verdict();
   end
endmodule
